// *** include/clock_source_params.svh ***
`ifndef CLOCK_SOURCE_PARAMS_SVH
`define CLOCK_SOURCE_PARAMS_SVH

// register offsets
`define ADDR_ENABLE1        12'h204
`define ADDR_ENABLE1_CLEAR  12'h244
`define ADDR_MAIN_PRESEL    12'h280
`define ADDR_MAIN_FINALSEL  12'h284
`define ADDR_OUT_SEL        12'h288
`define ADDR_PLL_IN_SEL     12'h290
`define ADDR_CONV_SEL       12'h2a4
`define ADDR_SWITCH_STATUS  12'h2f0

// implemented enable bits
`define ENABLE1_IMPL_MASK   32'h0e07fc05

// reset values
`define RST_ENABLE1         32'h00000000
`define RST_MAIN_PRESEL     2'h0
`define RST_MAIN_FINALSEL   2'h0
`define RST_SEL3            3'h7

// selector codes
`define SEL3_NONE           3'h7
`define FINAL_FROM_PRE      2'h0
`define FINAL_RESERVED      2'h1
`define FINAL_PLL           2'h2
`define FINAL_RTC           2'h3

// status field positions
`define STAT_MAIN_LSB       0
`define STAT_BUSY_BIT       4
`define STAT_OUT_LSB        8
`define STAT_PLL_LSB        12
`define STAT_CONV_LSB       16

`endif

// *** include/clock_source_pkg.sv ***
package clock_source_pkg;

  // register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // raw source clock levels
  typedef struct packed {
    logic internal_osc_12mhz;
    logic clock_input_ext;
    logic watchdog_osc;
    logic internal_osc_high_freq;
    logic pll_output;
    logic rtc_osc_32khz;
  } clock_sources_t;

  // clocks derived from the main clock
  typedef struct packed {
    logic core;
    logic memory;
    logic bus;
  } derived_clocks_t;

  // main clock switch sequencer
  typedef enum logic [1:0] {
    ST_RUN,
    ST_OLD_LOW,
    ST_NEW_LOW
  } main_switch_t;

endpackage

// *** logic/clock_source_selection.sv ***
`timescale 1ns/1ps
`include "clock_source_params.svh"

module clock_source_selection #(
  parameter logic [31:0] IMPL_MASK = `ENABLE1_IMPL_MASK
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  // register port
  input  wire clock_source_pkg::bus_req_t       bus_req,
  output logic [31:0]                           rd_data,
  // source clock levels
  input  wire clock_source_pkg::clock_sources_t src,
  // selected clocks and state
  output logic [31:0]                           periph_clock_enable1,
  output logic                                  main_clock,
  output clock_source_pkg::derived_clocks_t     derived,
  output logic                                  clock_output_pin,
  output logic                                  pll_input_clock,
  output logic                                  converter_clock,
  output logic                                  main_switch_busy
);

  // source level of the first main stage
  function automatic logic pre_level(input logic [1:0] code,
                                     input clock_source_pkg::clock_sources_t s);
    unique case (code)
      2'h0: pre_level = s.internal_osc_12mhz;
      2'h1: pre_level = s.clock_input_ext;
      2'h2: pre_level = s.watchdog_osc;
      2'h3: pre_level = s.internal_osc_high_freq;
    endcase
  endfunction

  // source level of the whole main path, code is {final, pre}
  function automatic logic main_level(input logic [3:0] code,
                                      input clock_source_pkg::clock_sources_t s);
    unique case (code[3:2])
      `FINAL_FROM_PRE: main_level = pre_level(code[1:0], s);
      `FINAL_RESERVED: main_level = 1'b0;
      `FINAL_PLL:      main_level = s.pll_output;
      `FINAL_RTC:      main_level = s.rtc_osc_32khz;
    endcase
  endfunction

  // gated selector step: move only while output and new source are low
  function automatic logic [2:0] sel_step(input logic [2:0] req,
                                          input logic [2:0] act,
                                          input logic       out_lvl,
                                          input logic       new_lvl);
    sel_step = (req != act && !out_lvl && !new_lvl) ? req : act;
  endfunction

  // software registers
  logic [31:0] enable_r;
  logic [31:0] enable_nxt;
  logic [1:0]  pre_r;
  logic [1:0]  fin_r;
  logic [2:0]  out_sel_r;
  logic [2:0]  pll_sel_r;
  logic [2:0]  conv_sel_r;
  logic [31:0] rd_data_r;
  logic [31:0] rd_data_nxt;

  // active selections and clock outputs
  logic [3:0]                       main_act_r;
  logic [3:0]                       main_act_nxt;
  clock_source_pkg::main_switch_t   st_r;
  clock_source_pkg::main_switch_t   st_nxt;
  logic                             main_clk_r;
  logic                             main_clk_nxt;
  logic [2:0]                       out_act_r;
  logic [2:0]                       out_act_nxt;
  logic [2:0]                       pll_act_r;
  logic [2:0]                       pll_act_nxt;
  logic [2:0]                       conv_act_r;
  logic [2:0]                       conv_act_nxt;
  logic                             out_clk_r;
  logic                             pll_clk_r;
  logic                             conv_clk_r;

  // address decode
  wire wr_en1    = bus_req.wr && bus_req.addr == `ADDR_ENABLE1;
  wire wr_clr1   = bus_req.wr && bus_req.addr == `ADDR_ENABLE1_CLEAR;
  wire wr_pre    = bus_req.wr && bus_req.addr == `ADDR_MAIN_PRESEL;
  wire wr_fin    = bus_req.wr && bus_req.addr == `ADDR_MAIN_FINALSEL;
  wire wr_outsel = bus_req.wr && bus_req.addr == `ADDR_OUT_SEL;
  wire wr_pllsel = bus_req.wr && bus_req.addr == `ADDR_PLL_IN_SEL;
  wire wr_conv   = bus_req.wr && bus_req.addr == `ADDR_CONV_SEL;

  // enable register: direct write, or clear through the alias
  assign enable_nxt = wr_en1  ? (bus_req.wdata & IMPL_MASK) :
                      wr_clr1 ? (enable_r & ~bus_req.wdata) :
                      enable_r;

  // status word for the switch state
  wire [31:0] status_word = (32'(main_act_r) << `STAT_MAIN_LSB)
                          | (32'(main_switch_busy) << `STAT_BUSY_BIT)
                          | (32'(out_act_r) << `STAT_OUT_LSB)
                          | (32'(pll_act_r) << `STAT_PLL_LSB)
                          | (32'(conv_act_r) << `STAT_CONV_LSB);

  // read mux, clear alias and unmapped addresses read zero
  always_comb begin
    rd_data_nxt = 32'h00000000;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `ADDR_ENABLE1:       rd_data_nxt = enable_r;
        `ADDR_MAIN_PRESEL:   rd_data_nxt = 32'(pre_r);
        `ADDR_MAIN_FINALSEL: rd_data_nxt = 32'(fin_r);
        `ADDR_OUT_SEL:       rd_data_nxt = 32'(out_sel_r);
        `ADDR_PLL_IN_SEL:    rd_data_nxt = 32'(pll_sel_r);
        `ADDR_CONV_SEL:      rd_data_nxt = 32'(conv_sel_r);
        `ADDR_SWITCH_STATUS: rd_data_nxt = status_word;
        default:             rd_data_nxt = 32'h00000000;
      endcase
    end
  end

  // register file
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_r   <= `RST_ENABLE1;
      pre_r      <= `RST_MAIN_PRESEL;
      fin_r      <= `RST_MAIN_FINALSEL;
      out_sel_r  <= `RST_SEL3;
      pll_sel_r  <= `RST_SEL3;
      conv_sel_r <= `RST_SEL3;
      rd_data_r  <= 32'h00000000;
    end else begin
      enable_r   <= enable_nxt;
      pre_r      <= wr_pre    ? bus_req.wdata[1:0] : pre_r;
      fin_r      <= wr_fin    ? bus_req.wdata[1:0] : fin_r;
      out_sel_r  <= wr_outsel ? bus_req.wdata[2:0] : out_sel_r;
      pll_sel_r  <= wr_pllsel ? bus_req.wdata[2:0] : pll_sel_r;
      conv_sel_r <= wr_conv   ? bus_req.wdata[2:0] : conv_sel_r;
      rd_data_r  <= rd_data_nxt;
    end
  end

  // main clock switch: old source must pass low, then new source
  wire [3:0] main_req = {fin_r, pre_r};
  wire       old_lvl  = main_level(main_act_r, src);
  wire       new_lvl  = main_level(main_req, src);

  always_comb begin
    st_nxt       = st_r;
    main_act_nxt = main_act_r;
    unique case (st_r)
      clock_source_pkg::ST_RUN:
        if (main_req != main_act_r) st_nxt = clock_source_pkg::ST_OLD_LOW;
      clock_source_pkg::ST_OLD_LOW:
        if (!old_lvl) st_nxt = clock_source_pkg::ST_NEW_LOW;
      clock_source_pkg::ST_NEW_LOW:
        if (!new_lvl) begin
          st_nxt       = clock_source_pkg::ST_RUN;
          main_act_nxt = main_req;
        end
      default: st_nxt = clock_source_pkg::ST_RUN;  // unused state code
    endcase
  end

  // main output follows the active source, held low in the gap
  assign main_clk_nxt = (st_nxt == clock_source_pkg::ST_NEW_LOW) ? 1'b0 :
                        main_level(main_act_nxt, src);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r       <= clock_source_pkg::ST_RUN;
      main_act_r <= {`RST_MAIN_FINALSEL, `RST_MAIN_PRESEL};
      main_clk_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      main_act_r <= main_act_nxt;
      main_clk_r <= main_clk_nxt;
    end
  end

  // levels of each 3-bit selector's candidate sources
  function automatic logic out_level(input logic [2:0] code, input logic m,
                                     input clock_source_pkg::clock_sources_t s);
    unique case (code)
      3'h0: out_level = m;
      3'h1: out_level = s.clock_input_ext;
      3'h2: out_level = s.watchdog_osc;
      3'h3: out_level = s.internal_osc_high_freq;
      3'h4: out_level = s.pll_output;
      3'h5: out_level = s.internal_osc_12mhz;
      3'h6: out_level = s.rtc_osc_32khz;
      3'h7: out_level = 1'b0;
    endcase
  endfunction

  function automatic logic pll_level(input logic [2:0] code,
                                     input clock_source_pkg::clock_sources_t s);
    unique case (code)
      3'h0:    pll_level = s.internal_osc_12mhz;
      3'h1:    pll_level = s.clock_input_ext;
      3'h3:    pll_level = s.rtc_osc_32khz;
      default: pll_level = 1'b0;
    endcase
  endfunction

  function automatic logic conv_level(input logic [2:0] code, input logic m,
                                      input clock_source_pkg::clock_sources_t s);
    unique case (code)
      3'h0:    conv_level = m;
      3'h1:    conv_level = s.pll_output;
      3'h2:    conv_level = s.internal_osc_high_freq;
      default: conv_level = 1'b0;
    endcase
  endfunction

  // 3-bit selectors change only across a low phase
  assign out_act_nxt  = sel_step(out_sel_r, out_act_r, out_clk_r,
                                 out_level(out_sel_r, main_clk_r, src));
  assign pll_act_nxt  = sel_step(pll_sel_r, pll_act_r, pll_clk_r,
                                 pll_level(pll_sel_r, src));
  assign conv_act_nxt = sel_step(conv_sel_r, conv_act_r, conv_clk_r,
                                 conv_level(conv_sel_r, main_clk_r, src));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_act_r  <= `RST_SEL3;
      pll_act_r  <= `RST_SEL3;
      conv_act_r <= `RST_SEL3;
      out_clk_r  <= 1'b0;
      pll_clk_r  <= 1'b0;
      conv_clk_r <= 1'b0;
    end else begin
      out_act_r  <= out_act_nxt;
      pll_act_r  <= pll_act_nxt;
      conv_act_r <= conv_act_nxt;
      out_clk_r  <= out_level(out_act_nxt, main_clk_r, src);
      pll_clk_r  <= pll_level(pll_act_nxt, src);
      conv_clk_r <= conv_level(conv_act_nxt, main_clk_r, src);
    end
  end

  // outputs
  assign rd_data              = rd_data_r;
  assign periph_clock_enable1 = enable_r;
  assign main_clock           = main_clk_r;
  assign derived              = {main_clk_r, main_clk_r, main_clk_r};
  assign clock_output_pin     = out_clk_r;
  assign pll_input_clock      = pll_clk_r;
  assign converter_clock      = conv_clk_r;
  assign main_switch_busy     = (st_r != clock_source_pkg::ST_RUN);

  // checks
  clear_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_clr1 |=> enable_r == ($past(enable_r) & ~$past(bus_req.wdata)))
    else $error("clear alias did not clear enable bits");

  clear_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (bus_req.rd && bus_req.addr == `ADDR_ENABLE1_CLEAR) |=> rd_data == 32'h00000000)
    else $error("clear alias read not zero");

  main_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> (pre_r == 2'h0 && fin_r == 2'h0 && main_act_r == 4'h0))
    else $error("main selectors not reset to zero");

  main_pll_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == clock_source_pkg::ST_RUN && main_act_r[3:2] == `FINAL_PLL
     && main_req == main_act_r) |=> main_clock == $past(src.pll_output))
    else $error("main clock not following pll");

  main_derive_a: assert property (@(posedge clk) disable iff (sys_rst)
    derived.core == main_clock && derived.memory == main_clock
    && derived.bus == main_clock)
    else $error("derived clocks differ from main clock");

  main_switch_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(main_act_r) |-> ($past(st_r) == clock_source_pkg::ST_NEW_LOW
    && !main_clock && main_act_r == $past(main_req)))
    else $error("main switch without low phases");

  sel3_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> (out_sel_r == 3'h7 && pll_sel_r == 3'h7 && conv_sel_r == 3'h7))
    else $error("3-bit selectors not reset to seven");

  clock_output_pin_main_a: assert property (@(posedge clk) disable iff (sys_rst)
    (out_act_r == 3'h0 && out_sel_r == 3'h0) |=> clock_output_pin == $past(main_clock))
    else $error("clock output not following main clock");

  pll_none_a: assert property (@(posedge clk) disable iff (sys_rst)
    (pll_act_r == `SEL3_NONE) |-> !pll_input_clock)
    else $error("pll input toggles with no source");

  conv_pll_a: assert property (@(posedge clk) disable iff (sys_rst)
    (conv_act_r == 3'h1 && conv_sel_r == 3'h1) |=> converter_clock == $past(src.pll_output))
    else $error("converter clock not following pll");

  none_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    (out_act_r == `SEL3_NONE) [*3] |-> !clock_output_pin && !$past(clock_output_pin))
    else $error("clock output active with no source");

  switch_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(out_act_r) |-> !clock_output_pin && !$past(clock_output_pin))
    else $error("clock output switched mid pulse");

endmodule // clock_source_selection

// *** testbench/clock_source_selection_test.sv ***
`timescale 1ns/1ps
`include "clock_source_params.svh"

module clock_source_selection_test;
  // design ports
  logic                              clk;
  logic                              sys_rst;
  clock_source_pkg::bus_req_t        bus_req;
  logic [31:0]                       rd_data;
  clock_source_pkg::clock_sources_t  src;
  logic [31:0]                       enable1;
  logic                              main_clock;
  clock_source_pkg::derived_clocks_t derived;
  logic                              out_pin;
  logic                              pll_in;
  logic                              conv_clk;
  logic                              busy;
  // expectation notes and counters
  typedef struct packed {logic [2:0] what; logic [31:0] exp;} note_t;
  note_t                             look_q[$];
  logic [31:0]                       rd_q[$];
  logic                              rd_d;
  logic                              look;
  int                                miscompares;
  int                                checks_done;
  logic [31:0]                       w;
  logic [31:0]                       c;
  // 3-bit selector table: address, code, source bit (6 = none), output
  localparam logic [11:0] sa [16] = '{12'h288, 12'h288, 12'h288, 12'h288, 12'h288, 12'h288,
    12'h288, 12'h288, 12'h290, 12'h290, 12'h290, 12'h290, 12'h2a4, 12'h2a4, 12'h2a4, 12'h2a4};
  localparam logic [2:0] sc [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 1, 3, 7, 0, 1, 2, 7};
  localparam int sb [16] = '{5, 4, 3, 2, 1, 5, 0, 6, 5, 4, 0, 6, 5, 1, 2, 6};
  localparam logic [2:0] sw [16] = '{1, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3};
  // main clock table: address, code, source bit
  localparam logic [11:0] ma [7] = '{12'h280, 12'h280, 12'h280, 12'h280,
    12'h284, 12'h284, 12'h284};
  localparam logic [1:0] mc [7] = '{1, 2, 3, 0, 2, 3, 0};
  localparam int mb [7] = '{4, 3, 2, 5, 1, 0, 5};
  // reset read table
  localparam logic [11:0] ra [8] = '{12'h204, 12'h244, 12'h280, 12'h284, 12'h288, 12'h290,
    12'h2a4, 12'h300};
  localparam logic [31:0] rv [8] = '{0, 0, 0, 0, 7, 7, 7, 0};

  clock_source_selection i_clock_source_selection (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .bus_req              (bus_req),
    .rd_data              (rd_data),
    .src                  (src),
    .periph_clock_enable1 (enable1),
    .main_clock           (main_clock),
    .derived              (derived),
    .clock_output_pin     (out_pin),
    .pll_input_clock      (pll_in),
    .converter_clock      (conv_clk),
    .main_switch_busy     (busy)
  );

  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // shared compare
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // observed output group
  function automatic logic [31:0] obs(input logic [2:0] what);
    case (what)
      3'h0: obs = {28'h0, derived, main_clock};
      3'h1: obs = {31'h0, out_pin};
      3'h2: obs = {31'h0, pll_in};
      3'h3: obs = {31'h0, conv_clk};
      3'h4: obs = {31'h0, busy};
      default: obs = enable1;
    endcase
  endfunction

  // monitor: oldest note against each result
  always @(posedge clk) rd_d <= bus_req.rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1 && rd_q.size() > 0) cmp(rd_data, rd_q.pop_front());
    if (look === 1'b1 && look_q.size() > 0) begin
      cmp(obs(look_q[0].what), look_q[0].exp);
      void'(look_q.pop_front());
    end
  end

  // bus master and observation tasks
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd_q.push_back(e);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
  endtask
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    rd_q.push_back(e);
    bus_req <= '{addr: 12'h204, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
  endtask
  task automatic chk(input logic [2:0] what, input logic [31:0] e);
    @(posedge clk);
    look_q.push_back(note_t'{what: what, exp: e});
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
  endtask
  task automatic settle(input logic [5:0] s);
    @(posedge clk);
    src <= clock_source_pkg::clock_sources_t'(s);
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_idle;
    repeat (3) @(posedge clk);
    for (int n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clk);
    chk(3'h4, 32'h0);
  endtask

  // verdict
  task automatic summarize;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog
  initial begin
    #50000;
    miscompares++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    summarize();
  end

  // main sequence
  initial begin
    sys_rst = 1'b1;
    bus_req = '0;
    src = '1;
    look = 1'b0;
    miscompares = 0;
    checks_done = 0;
    void'($urandom(32'h404df1d7));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values, write-only alias and unmapped address
    for (int i = 0; i < 8; i++) reg_rd(ra[i], rv[i]);
    chk(3'h1, 32'h0);
    chk(3'h2, 32'h0);
    chk(3'h3, 32'h0);
    chk(3'h0, 32'hf);
    // clear alias, zeros kept on reserved positions
    for (int i = 0; i < 4; i++) begin
      w = $urandom();
      c = (i == 0) ? 32'h0 : ($urandom() & `ENABLE1_IMPL_MASK);
      reg_wr(12'h204, w);
      wr_rd(12'h244, c, w & `ENABLE1_IMPL_MASK & ~c);
      chk(3'h5, w & `ENABLE1_IMPL_MASK & ~c);
      reg_rd(12'h244, 32'h0);
    end
    // every code of the output selector; pll and converter selector codes that pick a source, plus 7
    for (int i = 0; i < 16; i++) begin
      settle(6'h0);
      reg_wr(sa[i], {29'h0, sc[i]});
      reg_rd(sa[i], {29'h0, sc[i]});
      settle(6'h1 << sb[i]);
      chk(sw[i], {31'h0, sb[i] != 6});
      settle(~(6'h1 << sb[i]));
      chk(sw[i], 32'h0);
    end
    // every code of the first main stage, and final stage codes 0, 2 and 3
    for (int i = 0; i < 7; i++) begin
      settle(6'h0);
      reg_wr(ma[i], {30'h0, mc[i]});
      wait_idle();
      reg_rd(ma[i], {30'h0, mc[i]});
      settle(6'h1 << mb[i]);
      chk(3'h0, 32'hf);
      settle(~(6'h1 << mb[i]));
      chk(3'h0, 32'h0);
    end
    // switch held until old then new source pass low, both kept running
    settle(6'h22);
    reg_wr(12'h284, 32'h2);
    repeat (3) @(posedge clk);
    chk(3'h4, 32'h1);
    reg_rd(12'h2f0, 32'h00077710);
    chk(3'h0, 32'hf);
    settle(6'h02);
    chk(3'h0, 32'h0);
    chk(3'h4, 32'h1);
    settle(6'h00);
    wait_idle();
    reg_rd(12'h2f0, 32'h00077708);
    settle(6'h02);
    chk(3'h0, 32'hf);
    summarize();
  end
endmodule // clock_source_selection_test
